// file: rtl/slbe_uart.sv
// Serial channel with sync-break transmit and receive, registers on a plain port.
// How it works
// RQ1 - Two requests; receive outranks transmit.
// RQ2 - Receive request when character reaches buffer.
// RQ3 - Receive request also on reception error.
// RQ4 - No receive request while receiver disabled.
// RQ5 - Transmit request on each shift-register load.
// RQ6 - Full duplex; 7/8 bits, parity, 1/2 stops.
// RQ7 - Control register picks length, parity, stops, order.
// RQ8 - Option bit inverts serial output.
// RQ9 - Break trigger drives low 13 to 20 bits.
// RQ10 - Transmit request at start of break.
// RQ11 - Break end self-clears trigger, normal mode.
// RQ12 - Transmitter idles until data or trigger.
// RQ13 - Break-receive trigger enters break-receive wait.
// RQ14 - Break length counted in bit times.
// RQ15 - Break of 11+ bits: request, clear busy.
// RQ16 - Valid break: no flags, no buffer load.
// RQ17 - Break of 10 or fewer: silent, rewait.
// RQ18 - Software never triggers during break reception.
// RQ19 - Break sent during reception gives framing error.
// RQ20 - Power bit sets output to idle high.
// RQ21 - Data write starts frame; framing added.
// RQ22 - Software writes next data after transmit request.
// RQ23 - Break length code 101 means 13 bits.
// RQ24 - Both trigger bits read as zero.
// RQ25 - Error flags clear only by writing zero; here also cleared while receiver off.
// RQ26 - Break-receive trigger sets busy flag until valid break.
`include "slbe_defines.svh"
module slbe_uart import slbe_pkg::*; (
  // Clock and reset.
  input  wire logic       i_mclk,
  input  wire logic       i_rstn,
  // Register port.
  input  wire logic [2:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  // Serial pins.
  input  wire logic       i_serial_in_pin,
  output logic            o_serial_out_pin,
  // Interrupt requests.
  output logic            o_rx_complete_irq,
  output logic            o_tx_enable_irq,
  output logic      [1:0] o_irq_top
);

  slbe_state_type s_r;    // All registered state.
  slbe_state_type s_nxt;  // Its next value.
  logic       tx_on;      // Transmitter powered and enabled.
  logic       rx_on;      // Receiver powered and enabled.
  logic       lsb;        // Least significant bit first.
  logic [7:0] dmask;      // Data bits that belong to a character.
  logic [4:0] last_bit;   // Index of the final data bit.
  logic [4:0] brk_len;    // Break width in bit times.
  logic       tx_end;     // Transmit bit time complete.
  logic       rx_end;     // Receive bit time complete.
  logic       rx_half;    // Receive mid-start sample point.
  logic       rx_lvl;     // Synchronised receive level.
  logic [2:0] rx_idx;     // Buffer slot for the current bit.
  logic       rx_stop;    // Stop bit sampled this cycle.

  // Decoded configuration, all from registers.
  always_comb begin
    tx_on    = s_r.ctl[`SLBE_C_PWR] & s_r.ctl[`SLBE_C_TXE];
    rx_on    = s_r.ctl[`SLBE_C_PWR] & s_r.ctl[`SLBE_C_RXE];
    lsb      = s_r.ctl[`SLBE_C_LSB];
    // A 7-bit character sits low when LSB first, high when MSB first.
    dmask    = s_r.ctl[`SLBE_C_CL] ? 8'hff : (lsb ? 8'h7f : 8'hfe); // RQ6
    last_bit = s_r.ctl[`SLBE_C_CL] ? 5'h07 : 5'h06; // RQ7
    // Code 101 maps to 13, wrapping round to 100 for 20.
    brk_len  = `SLBE_BRK_BASE + {2'h0, 3'(s_r.sbl + 3'h3)}; // RQ23
    tx_end   = (s_r.tx_cnt == s_r.brg);
    rx_end   = (s_r.rx_cnt == s_r.brg);
    rx_half  = (s_r.rx_cnt == {1'b0, s_r.brg[7:1]});
    rx_lvl   = s_r.sy2;
    rx_idx   = lsb ? s_r.rx_bit[2:0] : 3'(3'h7 - s_r.rx_bit[2:0]);
    rx_stop  = (s_r.rx_st == RX_STOP) && rx_end;
  end

  // Bit to send at a given data position, honouring bit order.
  function automatic logic pick(input logic [7:0] d, input logic [4:0] i, input logic l);
    return l ? d[i[2:0]] : d[3'(3'h7 - i[2:0])]; // RQ7
  endfunction

  // Next-state logic for registers, transmitter and receiver.
  always_comb begin
    s_nxt = s_r;
    s_nxt.tx_irq = 1'b0;
    s_nxt.rx_irq = 1'b0;
    s_nxt.rdata  = 8'h00;
    // Two-stage synchroniser; the first stage feeds only the second.
    s_nxt.sy1 = i_serial_in_pin;
    s_nxt.sy2 = s_r.sy1;

    // Register writes come first so hardware sets below win.
    if (i_wr) begin
      case (i_addr)
        `SLBE_A_CTL: s_nxt.ctl = i_wdata; // RQ7
        `SLBE_A_OPT: begin
          s_nxt.sbl = i_wdata[4:2];
          s_nxt.tdl = i_wdata[`SLBE_O_TDL];
          // Triggers are ignored during break reception.
          if (i_wdata[`SLBE_O_SRT] && rx_on && !s_r.srf) begin
            s_nxt.srf = 1'b1; // RQ13 RQ26 RQ18
          end
          if (i_wdata[`SLBE_O_STT] && tx_on && !s_r.srf) begin
            s_nxt.stt = 1'b1; // RQ9 RQ18
          end
        end
        `SLBE_A_STR: begin
          // A one keeps the flag; only a zero clears it.
          s_nxt.pe  = s_r.pe & i_wdata[`SLBE_S_PE]; // RQ25
          s_nxt.fe  = s_r.fe & i_wdata[`SLBE_S_FE]; // RQ25
          s_nxt.ove = s_r.ove & i_wdata[`SLBE_S_OVE]; // RQ25
        end
        `SLBE_A_TX: begin
          s_nxt.tdr = i_wdata;
          // Data is only queued while the transmitter may run.
          if (tx_on) begin
            s_nxt.tdr_full = 1'b1; // RQ21
            s_nxt.tsf      = 1'b1;
          end
        end
        `SLBE_A_BRG: s_nxt.brg = i_wdata;
        default: ;
      endcase
    end

    // Reads answer in the next cycle; unmapped reads return zero.
    if (i_rd) begin
      case (i_addr)
        `SLBE_A_CTL: s_nxt.rdata = s_r.ctl;
        // Trigger bits always read back as zero.
        `SLBE_A_OPT: s_nxt.rdata = {s_r.srf, 2'h0, s_r.sbl, 1'b0, s_r.tdl}; // RQ24
        `SLBE_A_STR: s_nxt.rdata = {s_r.tsf, 4'h0, s_r.pe, s_r.fe, s_r.ove};
        `SLBE_A_RX: begin
          s_nxt.rdata   = s_r.rdr;
          s_nxt.rx_full = 1'b0;
        end
        `SLBE_A_TX: s_nxt.rdata = s_r.tdr;
        `SLBE_A_BRG: s_nxt.rdata = s_r.brg;
        default: s_nxt.rdata = 8'h00;
      endcase
    end

    // Transmitter; held idle and high while off.
    if (!tx_on) begin
      s_nxt.tx_st    = TX_IDLE;
      s_nxt.tx_line  = 1'b1; // RQ20
      s_nxt.tdr_full = 1'b0;
      s_nxt.tsf      = 1'b0;
      s_nxt.stt      = 1'b0;
      s_nxt.tx_cnt   = 8'h00;
    end else begin
      s_nxt.tx_cnt = tx_end ? 8'h00 : 8'(s_r.tx_cnt + 8'h01);
      case (s_r.tx_st)
        TX_IDLE: begin
          s_nxt.tx_line = 1'b1;
          s_nxt.tx_cnt  = 8'h00;
          s_nxt.tx_bit  = 5'h00;
          // A pending break goes before queued data.
          if (s_r.stt) begin
            s_nxt.tx_st   = TX_BRK;
            s_nxt.tx_line = 1'b0;
            s_nxt.tx_irq  = 1'b1; // RQ10
            // A break on a busy line spoils the character in flight.
            if (s_r.rx_st != RX_IDLE && !s_r.srf) begin
              s_nxt.clash = 1'b1; // RQ19
            end
          end else if (s_r.tdr_full) begin
            s_nxt.tx_st    = TX_START;
            s_nxt.tx_sh    = s_r.tdr;
            // A data write landing in this very cycle stays queued behind the load.
            s_nxt.tdr_full = i_wr && (i_addr == `SLBE_A_TX); // RQ21
            s_nxt.tx_line  = 1'b0; // RQ21
            s_nxt.tx_irq   = 1'b1; // RQ5
          end else begin
            // Nothing queued: stay idle.
            s_nxt.tsf = s_r.tdr_full | (i_wr && i_addr == `SLBE_A_TX); // RQ12
          end
        end
        TX_START: begin
          if (tx_end) begin
            s_nxt.tx_st   = TX_DATA;
            s_nxt.tx_line = pick(s_r.tx_sh, 5'h00, lsb);
          end
        end
        TX_DATA: begin
          if (tx_end) begin
            if (s_r.tx_bit == last_bit) begin
              s_nxt.tx_bit = 5'h00;
              if (s_r.ctl[`SLBE_C_PS1] | s_r.ctl[`SLBE_C_PS0]) begin
                s_nxt.tx_st = TX_PAR;
                // Odd 10, even 11, zero 01.
                s_nxt.tx_line = s_r.ctl[`SLBE_C_PS1] &
                  (^(s_r.tx_sh & dmask) ^ ~s_r.ctl[`SLBE_C_PS0]); // RQ6
              end else begin
                s_nxt.tx_st   = TX_STOP;
                s_nxt.tx_line = 1'b1;
              end
            end else begin
              s_nxt.tx_bit  = 5'(s_r.tx_bit + 5'h01);
              s_nxt.tx_line = pick(s_r.tx_sh, 5'(s_r.tx_bit + 5'h01), lsb);
            end
          end
        end
        TX_PAR: begin
          if (tx_end) begin
            s_nxt.tx_st   = TX_STOP;
            s_nxt.tx_line = 1'b1;
          end
        end
        TX_STOP: begin
          if (tx_end) begin
            // A second stop bit only when selected.
            if (s_r.ctl[`SLBE_C_SL] && s_r.tx_bit == 5'h00) begin
              s_nxt.tx_bit = 5'h01; // RQ6
            end else begin
              s_nxt.tx_st = TX_IDLE; // RQ12
            end
          end
        end
        TX_BRK: begin
          s_nxt.tx_line = 1'b0; // RQ9
          if (tx_end) begin
            s_nxt.tx_bit = 5'(s_r.tx_bit + 5'h01);
            if (s_r.tx_bit == 5'(brk_len - 5'h01)) begin
              s_nxt.stt     = 1'b0; // RQ11
              s_nxt.tx_st   = TX_IDLE;
              s_nxt.tx_line = 1'b1;
            end
          end
        end
        default: s_nxt.tx_st = TX_IDLE;
      endcase
    end

    // Receiver; flags reset while off, buffer data only with power off.
    if (!rx_on) begin
      s_nxt.rx_st   = RX_IDLE;
      s_nxt.pe      = 1'b0;
      s_nxt.fe      = 1'b0;
      s_nxt.ove     = 1'b0;
      s_nxt.rx_full = 1'b0;
      s_nxt.srf     = 1'b0;
      s_nxt.clash   = 1'b0;
      s_nxt.rx_cnt  = 8'h00;
      if (!s_r.ctl[`SLBE_C_PWR]) begin
        s_nxt.rdr = `SLBE_RST_DATA;
      end
    end else begin
      s_nxt.rx_cnt = 8'(s_r.rx_cnt + 8'h01);
      case (s_r.rx_st)
        RX_IDLE: begin
          // Wait for a low line level, in break wait as in normal mode.
          s_nxt.rx_cnt = 8'h00;
          if (!rx_lvl) begin
            s_nxt.rx_st = RX_START; // RQ13
          end
        end
        RX_START: begin
          if (rx_half) begin
            s_nxt.rx_cnt = 8'h00;
            s_nxt.rx_bit = 5'h00;
            // A high level at mid start was a glitch.
            s_nxt.rx_st  = rx_lvl ? RX_IDLE : RX_DATA;
            // The shift register starts from all ones.
            s_nxt.rx_sh  = `SLBE_RST_DATA; // RQ16
          end
        end
        RX_DATA: begin
          if (rx_end) begin
            s_nxt.rx_cnt = 8'h00;
            if (s_r.srf) begin
              // Break mode: count low bit times, saturating.
              if (!rx_lvl) begin
                if (s_r.rx_bit != 5'h1f) begin
                  s_nxt.rx_bit = 5'(s_r.rx_bit + 5'h01); // RQ14
                end
              end else begin
                s_nxt.rx_st = RX_IDLE; // RQ17
                // The start bit counts toward the width; comparing the count itself
                // keeps a saturated long break from wrapping round to a short one.
                if (s_r.rx_bit >= 5'(`SLBE_BRK_MIN - 5'h01)) begin
                  s_nxt.srf    = 1'b0; // RQ15
                  s_nxt.rx_irq = 1'b1; // RQ15 RQ16
                end
                // Short break: no request, busy stays set.
              end
            end else begin
              s_nxt.rx_sh[rx_idx] = rx_lvl;
              if (s_r.rx_bit == last_bit) begin
                s_nxt.rx_st = (s_r.ctl[`SLBE_C_PS1] | s_r.ctl[`SLBE_C_PS0]) ?
                              RX_PAR : RX_STOP;
              end else begin
                s_nxt.rx_bit = 5'(s_r.rx_bit + 5'h01);
              end
            end
          end
        end
        RX_PAR: begin
          if (rx_end) begin
            s_nxt.rx_cnt = 8'h00;
            s_nxt.rx_par = rx_lvl;
            s_nxt.rx_st  = RX_STOP;
          end
        end
        RX_STOP: begin
          // Only the first stop bit is checked.
          if (rx_end) begin
            s_nxt.rx_st  = RX_IDLE;
            s_nxt.rx_irq = 1'b1; // RQ2 RQ3
            s_nxt.clash  = 1'b0;
            if (!rx_lvl || s_r.clash) begin
              s_nxt.fe = 1'b1; // RQ19
            end
            if (s_r.ctl[`SLBE_C_PS1] &
                (^(s_r.rx_sh & dmask) ^ s_r.rx_par ^ ~s_r.ctl[`SLBE_C_PS0])) begin
              s_nxt.pe = 1'b1;
            end
            // An unread buffer keeps its data; the new one is lost.
            if (s_nxt.rx_full) begin
              s_nxt.ove = 1'b1;
            end else begin
              s_nxt.rdr     = s_r.rx_sh & dmask; // RQ2
              s_nxt.rx_full = 1'b1;
            end
          end
        end
        default: s_nxt.rx_st = RX_IDLE;
      endcase
    end

    // Receiver request never leaves while reception is off.
    s_nxt.rx_irq  = s_nxt.rx_irq & s_nxt.ctl[`SLBE_C_PWR] & s_nxt.ctl[`SLBE_C_RXE]; // RQ4
    // Receive outranks transmit when both arrive together.
    s_nxt.irq_top = s_nxt.rx_irq ? 2'h1 : (s_nxt.tx_irq ? 2'h2 : 2'h0); // RQ1
    s_nxt.out     = s_nxt.tx_line ^ s_nxt.tdl; // RQ8

    // Synchronous reset to constants.
    if (!i_rstn) begin
      s_nxt         = '0;
      s_nxt.ctl     = `SLBE_RST_CTL;
      s_nxt.sbl     = `SLBE_RST_SBL; // RQ23
      s_nxt.brg     = `SLBE_RST_BRG;
      s_nxt.tdr     = `SLBE_RST_DATA;
      s_nxt.rdr     = `SLBE_RST_DATA;
      s_nxt.rx_sh   = `SLBE_RST_DATA;
      s_nxt.tx_line = 1'b1;
      s_nxt.out     = 1'b1;
      s_nxt.sy1     = 1'b1;
      s_nxt.sy2     = 1'b1;
    end
  end

  // State register.
  always_ff @(posedge i_mclk) begin
    s_r <= s_nxt;
  end

  assign o_rdata           = s_r.rdata;
  assign o_serial_out_pin  = s_r.out;
  assign o_rx_complete_irq = s_r.rx_irq;
  assign o_tx_enable_irq   = s_r.tx_irq;
  assign o_irq_top         = s_r.irq_top;

  // Checks on the behaviour above.
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  sequence s_opt_rd;
    i_rd && i_addr == `SLBE_A_OPT;
  endsequence
  sequence s_load;
    s_r.tx_st == TX_IDLE && tx_on && !s_r.stt && s_r.tdr_full;
  endsequence
  sequence s_brk_seen;
    s_r.rx_st == RX_DATA && rx_on && s_r.srf && rx_end && rx_lvl;
  endsequence

  property p_rx_off;
    !s_r.ctl[`SLBE_C_RXE] |-> !o_rx_complete_irq;
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("rx request while off"); // RQ4
  property p_trig_zero;
    s_opt_rd |=> o_rdata[`SLBE_O_SRT] == 1'b0 && o_rdata[`SLBE_O_STT] == 1'b0;
  endproperty
  a_trig_zero: assert property (p_trig_zero) else $error("trigger read nonzero"); // RQ24
  property p_load;
    s_load |=> o_tx_enable_irq && s_r.tx_st == TX_START ##1 !o_tx_enable_irq;
  endproperty
  a_load: assert property (p_load) else $error("no tx request on load"); // RQ5
  property p_brk_start;
    s_r.tx_st == TX_IDLE && tx_on && s_r.stt |=> o_tx_enable_irq && s_r.tx_st == TX_BRK;
  endproperty
  a_brk_start: assert property (p_brk_start) else $error("break start missed"); // RQ10
  property p_brk_low;
    s_r.tx_st == TX_BRK |-> o_serial_out_pin == s_r.tdl;
  endproperty
  a_brk_low: assert property (p_brk_low) else $error("break not low"); // RQ9
  property p_brk_end;
    s_r.tx_st == TX_BRK && tx_on && tx_end && s_r.tx_bit == 5'(brk_len - 5'h01)
      |=> !s_r.stt && s_r.tx_st == TX_IDLE;
  endproperty
  a_brk_end: assert property (p_brk_end) else $error("break trigger kept"); // RQ11
  property p_idle_high;
    s_r.tx_st == TX_IDLE |-> o_serial_out_pin != s_r.tdl;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("idle line not high"); // RQ20
  property p_str_clr;
    i_wr && i_addr == `SLBE_A_STR && !i_wdata[`SLBE_S_PE] && !rx_stop |=> !s_r.pe;
  endproperty
  a_str_clr: assert property (p_str_clr) else $error("parity flag not cleared"); // RQ25
  property p_srt_set;
    i_wr && i_addr == `SLBE_A_OPT && i_wdata[`SLBE_O_SRT] && rx_on && !s_r.srf |=> s_r.srf;
  endproperty
  a_srt_set: assert property (p_srt_set) else $error("busy flag not set"); // RQ26
  property p_brk_ok;
    s_brk_seen ##0 (s_r.rx_bit >= 5'h0a) |=> o_rx_complete_irq && !s_r.srf;
  endproperty
  a_brk_ok: assert property (p_brk_ok) else $error("valid break missed"); // RQ15
  property p_brk_short;
    s_brk_seen ##0 (s_r.rx_bit < 5'h0a) |=> !o_rx_complete_irq && s_r.srf;
  endproperty
  a_brk_short: assert property (p_brk_short) else $error("short break accepted"); // RQ17
endmodule

// file: rtl/slbe_defines.svh
// Register offsets, field positions, reset values and counts of the serial channel.
`ifndef SLBE_DEFINES_SVH
`define SLBE_DEFINES_SVH
`define SLBE_A_CTL 3'h0
`define SLBE_A_OPT 3'h1
`define SLBE_A_STR 3'h2
`define SLBE_A_RX 3'h3
`define SLBE_A_TX 3'h4
`define SLBE_A_BRG 3'h5
`define SLBE_C_PWR 7
`define SLBE_C_TXE 6
`define SLBE_C_RXE 5
`define SLBE_C_LSB 4
`define SLBE_C_PS1 3
`define SLBE_C_PS0 2
`define SLBE_C_CL 1
`define SLBE_C_SL 0
`define SLBE_O_SRF 7
`define SLBE_O_SRT 6
`define SLBE_O_STT 5
`define SLBE_O_TDL 0
`define SLBE_S_TSF 7
`define SLBE_S_PE 2
`define SLBE_S_FE 1
`define SLBE_S_OVE 0
`define SLBE_RST_CTL 8'h12
`define SLBE_RST_SBL 3'h5
`define SLBE_RST_BRG 8'h1f
`define SLBE_RST_DATA 8'hff
`define SLBE_BRK_BASE 5'h0d
`define SLBE_BRK_MIN 5'h0b
`endif

// file: rtl/slbe_pkg.sv
// Types shared by the serial channel: state machines and the state record.
package slbe_pkg;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP, TX_BRK} slbe_tx_type;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} slbe_rx_type;
  typedef struct packed {
    logic [7:0]  ctl;
    logic [2:0]  sbl;
    logic        tdl;
    logic [7:0]  brg;
    logic [7:0]  tdr;
    logic        tdr_full;
    logic        stt;
    logic        srf;
    logic        tsf;
    logic        pe;
    logic        fe;
    logic        ove;
    logic [7:0]  rdr;
    logic        rx_full;
    slbe_tx_type tx_st;
    logic [7:0]  tx_cnt;
    logic [4:0]  tx_bit;
    logic [7:0]  tx_sh;
    logic        tx_line;
    logic        tx_irq;
    slbe_rx_type rx_st;
    logic [7:0]  rx_cnt;
    logic [4:0]  rx_bit;
    logic [7:0]  rx_sh;
    logic        rx_par;
    logic        rx_irq;
    logic        clash;
    logic        sy1;
    logic        sy2;
    logic        out;
    logic [1:0]  irq_top;
    logic [7:0]  rdata;
  } slbe_state_type;
endpackage

// file: dv/slbe_remote_node.sv
// Model of the remote serial node: sends frames and breaks, captures frames from the channel.
module slbe_remote_node #(
  parameter int BIT_NS = 80  // Bit time of the link in ns.
) (
  // Serial line driven by the channel.
  input  wire logic i_line,
  // Serial line driven into the channel.
  output logic      o_line
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [10:0] rx_bits;  // Last captured frame, first bit after start in bit 0.

  // The line idles high, as a released transceiver output would.
  initial begin
    o_line = 1'b1;
  end

  // One frame of start, 8 data bits LSB first and a stop bit of chosen level.
  task automatic send(input logic [7:0] d, input logic stop);
    // Start just off the clock edge so the channel never samples a changing line.
    #3;
    o_line = 1'b0;
    #(BIT_NS);
    for (int i = 0; i < 8; i++) begin
      o_line = d[i];
      #(BIT_NS);
    end
    o_line = stop;
    #(BIT_NS);
    o_line = 1'b1;
    #(BIT_NS);
  endtask

  // A plain low stretch of n bit times, used as a break of chosen width.
  task automatic send_low(input int n);
    #3;
    o_line = 1'b0;
    #(n * BIT_NS);
    o_line = 1'b1;
    #(2 * BIT_NS);
  endtask

  // Samples each falling edge's frame at mid-bit; a few ns off the clock edge avoids races.
  always begin
    logic [10:0] tmp;
    @(negedge i_line);
    #(BIT_NS + BIT_NS / 2 + 5);
    for (int i = 0; i < 11; i++) begin
      tmp[i] = i_line;
      #(BIT_NS);
    end
    rx_bits = tmp;
  end
endmodule

// file: dv/slbe_uart_tb_top.sv
// Self-checking bench for the serial channel with sync-break support.
`include "slbe_defines.svh"
`define CHK(got, exp, msg) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp); \
    end \
  end

module slbe_uart_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic       i_mclk;             // Core clock, 50 MHz.
  logic       i_rstn;             // Synchronous reset, active low.
  logic [2:0] i_addr;             // Register address.
  logic [7:0] i_wdata;            // Register write data.
  logic       i_wr;               // Write strobe.
  logic       i_rd;               // Read strobe.
  logic [7:0] o_rdata;            // Read data, cycle after the strobe.
  logic       i_serial_in_pin;    // Line from the remote node.
  logic       o_serial_out_pin;   // Line to the remote node.
  logic       o_rx_complete_irq;  // Receive request pulse.
  logic       o_tx_enable_irq;    // Transmit request pulse.
  logic [1:0] o_irq_top;          // Winning request code.
  int         bad_count;          // Mismatches seen.
  int         comparisons;        // Comparisons made.
  int         cycles;             // Cycles since start, for the hang guard.
  int         n;                  // Low cycles of a break.
  logic       seen;               // A request pulse was caught.
  logic [1:0] top_seen;           // Priority code beside that pulse.
  logic [2:0] code;               // Break length code.
  logic [4:0] len;                // Break length in bits.

  // Free-running clock, 20 ns period.
  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end

  slbe_uart slbe_uart_inst (
    .i_mclk            (i_mclk),
    .i_rstn            (i_rstn),
    .i_addr            (i_addr),
    .i_wdata           (i_wdata),
    .i_wr              (i_wr),
    .i_rd              (i_rd),
    .o_rdata           (o_rdata),
    .i_serial_in_pin   (i_serial_in_pin),
    .o_serial_out_pin  (o_serial_out_pin),
    .o_rx_complete_irq (o_rx_complete_irq),
    .o_tx_enable_irq   (o_tx_enable_irq),
    .o_irq_top         (o_irq_top)
  );

  // Bit time 80 ns matches a rate register of 3 (four clocks per bit).
  slbe_remote_node #(.BIT_NS(80)) slbe_remote_node_inst (
    .i_line (o_serial_out_pin),
    .o_line (i_serial_in_pin)
  );

  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // The whole run needs under a thousand cycles; a hang is cut well above that.
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      $display("[FAIL] %0t run did not finish in time", $time);
      end_sim();
    end
  end

  // One-cycle write strobe; a gap cycle follows so strobes never collide.
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask

  // One-cycle read strobe; data is only valid in the following cycle.
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    `CHK(o_rdata, exp, "register read")
  endtask

  // Watches one request line for a pulse, bounded by max cycles.
  task automatic wait_irq(input logic rx, input int max);
    seen = 1'b0;
    top_seen = 2'h0;
    for (int i = 0; i < max && seen !== 1'b1; i++) begin
      @(posedge i_mclk);
      #1;
      if ((rx ? o_rx_complete_irq : o_tx_enable_irq) === 1'b1) begin
        seen = 1'b1;
        top_seen = o_irq_top;
      end
    end
  endtask

  // Sends one character and checks the request and the bits seen by the remote node.
  task automatic tx_frame(input logic [7:0] ctl, input logic [7:0] d, input logic [10:0] exp);
    wr(`SLBE_A_CTL, ctl);
    wr(`SLBE_A_TX, d);
    wait_irq(1'b0, 10);
    `CHK(seen, 1'b1, "tx request")
    `CHK(top_seen, 2'h2, "tx only code")
    #1200;
    `CHK(slbe_remote_node_inst.rx_bits, exp, "frame on line")
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  // Main sequence.
  initial begin
    i_rstn = 1'b0;
    i_addr = 3'h0;
    i_wdata = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    bad_count = 0;
    comparisons = 0;
    cycles = 0;
    repeat (8) @(posedge i_mclk);
    i_rstn <= 1'b1;
    rd(`SLBE_A_CTL, 8'h12);
    rd(`SLBE_A_OPT, 8'h14);
    rd(`SLBE_A_STR, 8'h00);
    rd(`SLBE_A_RX, 8'hff);
    rd(3'h6, 8'h00);
    done("reset");
    // Output level with power on, inverted and then true.
    wr(`SLBE_A_BRG, 8'h03);
    wr(`SLBE_A_OPT, 8'h15);
    wr(`SLBE_A_CTL, 8'h92);
    repeat (3) @(posedge i_mclk);
    #1;
    `CHK(o_serial_out_pin, 1'b0, "inverted idle")
    wr(`SLBE_A_OPT, 8'h14);
    repeat (3) @(posedge i_mclk);
    #1;
    `CHK(o_serial_out_pin, 1'b1, "idle high")
    done("level");
    // The inverted idle looked like a start bit to the remote node; let that capture end.
    #1000;
    // 8 bits LSB first no parity, then 7 bits MSB first even parity 2 stops.
    tx_frame(8'hf2, 8'ha5, 11'h7a5);
    tx_frame(8'hed, 8'h55, 11'h7aa);
    wr(`SLBE_A_CTL, 8'hf2);
    done("transmit");
    fork
      slbe_remote_node_inst.send(8'h3c, 1'b1);
      wait_irq(1'b1, 80);
    join
    `CHK(seen, 1'b1, "rx request")
    `CHK(top_seen, 2'h1, "rx code")
    rd(`SLBE_A_RX, 8'h3c);
    rd(`SLBE_A_STR, 8'h00);
    // A low stop bit is a framing error and still raises the request.
    fork
      slbe_remote_node_inst.send(8'h0f, 1'b0);
      wait_irq(1'b1, 80);
    join
    `CHK(seen, 1'b1, "error request")
    rd(`SLBE_A_STR, 8'h02);
    wr(`SLBE_A_STR, 8'hff);
    rd(`SLBE_A_STR, 8'h02);
    wr(`SLBE_A_STR, 8'h00);
    rd(`SLBE_A_STR, 8'h00);
    rd(`SLBE_A_RX, 8'h0f);
    // Receiver off: a whole frame passes without a request.
    wr(`SLBE_A_CTL, 8'hd2);
    fork
      slbe_remote_node_inst.send(8'h11, 1'b1);
      wait_irq(1'b1, 80);
    join
    `CHK(seen, 1'b0, "request while disabled")
    wr(`SLBE_A_CTL, 8'hf2);
    done("receive");
    // Shortest and longest break codes; length is only changed with the transmitter off.
    for (int k = 0; k < 2; k++) begin
      code = (k == 0) ? 3'h5 : 3'h4;
      len = (k == 0) ? 5'h0d : 5'h14;
      wr(`SLBE_A_CTL, 8'hb2);
      wr(`SLBE_A_OPT, {3'h0, code, 2'h0});
      wr(`SLBE_A_CTL, 8'hf2);
      wr(`SLBE_A_OPT, {3'h1, code, 2'h0});
      wait_irq(1'b0, 10);
      `CHK(seen, 1'b1, "break request")
      n = 1;
      while (n < 200 && o_serial_out_pin === 1'b0) begin
        @(posedge i_mclk);
        #1;
        if (o_serial_out_pin === 1'b0) n++;
      end
      `CHK(n, 4 * int'(len), "break width")
      wait_irq(1'b0, 20);
      `CHK(seen, 1'b0, "no frame after break")
      `CHK(o_serial_out_pin, 1'b1, "idle after break")
      rd(`SLBE_A_OPT, {3'h0, code, 2'h0});
    end
    done("break transmit");
    // Triggers are only written while no break reception is in progress.
    wr(`SLBE_A_OPT, {3'h2, code, 2'h0});
    rd(`SLBE_A_OPT, {3'h4, code, 2'h0});
    fork
      slbe_remote_node_inst.send_low(8);
      wait_irq(1'b1, 60);
    join
    `CHK(seen, 1'b0, "short break request")
    rd(`SLBE_A_OPT, {3'h4, code, 2'h0});
    fork
      slbe_remote_node_inst.send_low(12);
      wait_irq(1'b1, 80);
    join
    `CHK(seen, 1'b1, "valid break request")
    rd(`SLBE_A_OPT, {3'h0, code, 2'h0});
    rd(`SLBE_A_STR, 8'h00);
    rd(`SLBE_A_RX, 8'h0f);
    done("break receive");
    // A break sent while a character arrives spoils that character.
    fork
      slbe_remote_node_inst.send(8'h5a, 1'b1);
      begin
        repeat (10) @(posedge i_mclk);
        wr(`SLBE_A_OPT, {3'h1, code, 2'h0});
        wait_irq(1'b1, 80);
      end
    join
    `CHK(seen, 1'b1, "clash request")
    rd(`SLBE_A_STR, 8'h02);
    done("clash");
    end_sim();
  end
endmodule
